/* shared/sitd_params.svh */
// Offsets, field positions and reset values of the split isochronous decoder
`ifndef SITD_PARAMS_SVH
`define SITD_PARAMS_SVH

`define SITD_WORDS      7
`define W_LINK          3'h0
`define W_ROUTE         3'h1
`define W_MASKS         3'h2
`define W_STATE         3'h3
`define W_PAGE0         3'h4
`define W_PAGE1         3'h5
`define W_BACK          3'h6
`define W_LAST          3'h6

`define TERM_BIT        0
`define KIND_MSB        2
`define KIND_LSB        1
`define LINK_LSB        5
`define DIR_BIT         31
`define PORT_MSB        30
`define PORT_LSB        24
`define HUB_MSB         22
`define HUB_LSB         16
`define ENDPT_MSB       11
`define ENDPT_LSB       8
`define FADDR_MSB       6
`define FADDR_LSB       0
`define CMASK_LSB       8
`define SMASK_LSB       0
`define IOC_BIT         31
`define PAGE_BIT        30
`define ACTIVE_BIT      7
`define SPLIT_BIT       1
`define STATUS_MSB      7
`define OFFSET_MSB      11
`define PAGE_BASE_LSB   12
`define TPOS_MSB        4
`define TPOS_LSB        3
`define TCNT_MSB        2
`define TCNT_LSB        0

`define KIND_ITD        2'h0
`define KIND_QH         2'h1
`define KIND_SITD       2'h2
`define KIND_FSTN       2'h3

`define REG_STATUS      8'h00
`define REG_MASK        8'h04
`define REG_CTRL        8'h08
`define REG_STATE       8'h0C

`define EV_DONE         0
`define EV_BADLINK      1
`define EV_SKIP         2
`define EV_WIDTH        3
`define EV_RST          3'h0
`define CTRL_RST        1'h0
`define WORD_RST        32'h00000000

`endif

/* shared/sitd_pkg.sv */
// Types shared by the split isochronous descriptor decoder
package sitd_pkg;
	typedef enum logic {PH_START, PH_COMPLETE} split_phase_t;
	typedef logic [31:0] desc_word_t;
endpackage

/* rtl/split_iso_descriptor_decoder.sv */
// Fetch, decode and split scheduling of one split isochronous descriptor
`timescale 1ns/100ps
`include "sitd_params.svh"

module split_iso_descriptor_decoder
(
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic [7:0]         reg_addr_in,
	input  wire logic [31:0]        reg_wdata_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	output logic [31:0]             reg_rdata_out,
	input  wire sitd_pkg::desc_word_t desc_word_in,
	input  wire logic [2:0]         desc_index_in,
	input  wire logic               desc_valid_in,
	input  wire logic [2:0]         uframe_in,
	input  wire logic               uframe_tick_in,
	input  wire logic               threshold_tick_in,
	input  wire logic               txn_done_in,
	input  wire logic               txn_last_in,
	input  wire logic               page_advance_in,
	output logic                    start_split_out,
	output logic                    complete_split_out,
	output logic                    dir_in_out,
	output logic [6:0]              translator_port_out,
	output logic [6:0]              translator_hub_out,
	output logic [3:0]              target_endpoint_out,
	output logic [6:0]              function_address_out,
	output logic [31:0]             buffer_address_out,
	output logic [26:0]             next_element_link_out,
	output logic [1:0]              element_kind_out,
	output logic                    next_link_valid_out,
	output logic [26:0]             back_link_out,
	output logic                    back_link_valid_out,
	output logic [1:0]              transaction_position_out,
	output logic [2:0]              transaction_count_out,
	output logic                    wb_valid_out,
	output logic [2:0]              wb_index_out,
	output sitd_pkg::desc_word_t    wb_word_out,
	output logic                    irq_out
);
	import sitd_pkg::*;

	// Link kinds that a periodic element may legally point at
	function automatic logic link_kind_ok(input logic [1:0] kind);
		link_kind_ok = (kind != `KIND_FSTN);
	endfunction

	desc_word_t                 desc_r [`SITD_WORDS];
	desc_word_t                 desc_nxt [`SITD_WORDS];
	logic                       loaded_r;
	logic                       loaded_nxt;
	logic                       enable_r;
	logic                       enable_nxt;
	logic                       pend_r;
	logic                       pend_nxt;
	logic [`EV_WIDTH-1:0]       status_r;
	logic [`EV_WIDTH-1:0]       status_nxt;
	logic [`EV_WIDTH-1:0]       mask_r;
	logic [`EV_WIDTH-1:0]       mask_nxt;
	logic [`EV_WIDTH-1:0]       ev;
	logic [31:0]                rdata_nxt;
	logic                       start_nxt;
	logic                       complete_nxt;
	logic [31:0]                buf_addr_nxt;
	logic                       wb_valid_nxt;
	desc_word_t                 wb_word_nxt;
	logic                       irq_nxt;
	logic                       active;
	logic                       start_hit;
	logic                       comp_hit;
	logic                       sched;
	split_phase_t               phase;

	// Decoded fields are slices of the stored words, so they track any update
	assign next_element_link_out = desc_r[`W_LINK][31:`LINK_LSB];
	assign element_kind_out = desc_r[`W_LINK][`KIND_MSB:`KIND_LSB];
	assign next_link_valid_out = !desc_r[`W_LINK][`TERM_BIT];
	assign back_link_out = desc_r[`W_BACK][31:`LINK_LSB];
	assign back_link_valid_out = !desc_r[`W_BACK][`TERM_BIT];
	assign dir_in_out = desc_r[`W_ROUTE][`DIR_BIT];
	assign translator_port_out =
		desc_r[`W_ROUTE][`PORT_MSB:`PORT_LSB];
	assign translator_hub_out = desc_r[`W_ROUTE][`HUB_MSB:`HUB_LSB];
	assign target_endpoint_out =
		desc_r[`W_ROUTE][`ENDPT_MSB:`ENDPT_LSB];
	assign function_address_out =
		desc_r[`W_ROUTE][`FADDR_MSB:`FADDR_LSB];
	assign transaction_position_out =
		desc_r[`W_PAGE1][`TPOS_MSB:`TPOS_LSB];
	assign transaction_count_out =
		desc_r[`W_PAGE1][`TCNT_MSB:`TCNT_LSB];
	assign wb_index_out = `W_STATE;

	always_comb
	begin
		desc_nxt = desc_r;
		loaded_nxt = loaded_r;
		enable_nxt = enable_r;
		pend_nxt = pend_r;
		mask_nxt = mask_r;
		ev = `EV_RST;
		wb_valid_nxt = 1'b0;
		rdata_nxt = 32'h00000000;

		// Word 0 restarts a fetch; the seventh word completes it
		if (desc_valid_in && desc_index_in <= `W_LAST)
		begin
			desc_nxt[desc_index_in] = desc_word_in;
			if (desc_index_in == `W_LINK)
				loaded_nxt = 1'b0;
			else if (desc_index_in == `W_LAST)
				loaded_nxt = 1'b1;
		end

		active = desc_r[`W_STATE][`ACTIVE_BIT];
		phase = desc_r[`W_STATE][`SPLIT_BIT] ? PH_COMPLETE : PH_START;
		start_hit = desc_r[`W_MASKS][`SMASK_LSB + uframe_in];
		comp_hit = desc_r[`W_MASKS][`CMASK_LSB + uframe_in];
		sched = uframe_tick_in && loaded_r && enable_r && active;
		start_nxt = sched && phase == PH_START && start_hit;
		complete_nxt = sched && phase == PH_COMPLETE && comp_hit;

		// A bad link is flagged, never followed
		if (sched && next_link_valid_out && !link_kind_ok(element_kind_out))
			ev[`EV_BADLINK] = 1'b1;
		if (uframe_tick_in && loaded_r && enable_r && !active)
			ev[`EV_SKIP] = 1'b1;

		// Threshold clears first, so a completion in this cycle stays pending
		if (threshold_tick_in && pend_r)
		begin
			pend_nxt = 1'b0;
			ev[`EV_DONE] = 1'b1;
		end

		// Only the state word is ever modified and returned
		if (txn_done_in && loaded_r && active)
		begin
			wb_valid_nxt = 1'b1;
			if (phase == PH_START)
				desc_nxt[`W_STATE][`SPLIT_BIT] = 1'b1;
			else if (txn_last_in)
			begin
				desc_nxt[`W_STATE][`SPLIT_BIT] = 1'b0;
				desc_nxt[`W_STATE][`ACTIVE_BIT] = 1'b0;
				if (desc_r[`W_STATE][`IOC_BIT])
					pend_nxt = 1'b1;
			end
		end
		if (page_advance_in && loaded_r && !dir_in_out)
		begin
			desc_nxt[`W_STATE][`PAGE_BIT] = 1'b1;
			wb_valid_nxt = 1'b1;
		end
		wb_word_nxt = desc_nxt[`W_STATE];

		buf_addr_nxt = {desc_nxt[`W_STATE][`PAGE_BIT] ?
			desc_nxt[`W_PAGE1][31:`PAGE_BASE_LSB] :
			desc_nxt[`W_PAGE0][31:`PAGE_BASE_LSB],
			desc_nxt[`W_PAGE0][`OFFSET_MSB:0]};

		// New events win over a simultaneous write-one-to-clear
		status_nxt = status_r;
		if (reg_wr_in && reg_addr_in == `REG_STATUS)
			status_nxt = status_r & ~reg_wdata_in[`EV_WIDTH-1:0];
		status_nxt = status_nxt | ev;
		if (reg_wr_in && reg_addr_in == `REG_MASK)
			mask_nxt = reg_wdata_in[`EV_WIDTH-1:0];
		if (reg_wr_in && reg_addr_in == `REG_CTRL)
			enable_nxt = reg_wdata_in[0];
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				`REG_STATUS: rdata_nxt = {29'h0, status_r};
				`REG_MASK:   rdata_nxt = {29'h0, mask_r};
				`REG_CTRL:   rdata_nxt = {31'h0, enable_r};
				`REG_STATE:  rdata_nxt = {27'h0, pend_r,
					desc_r[`W_STATE][`PAGE_BIT], active,
					desc_r[`W_STATE][`SPLIT_BIT], loaded_r};
				default:     rdata_nxt = 32'h00000000;
			endcase
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < `SITD_WORDS; i++)
				desc_r[i] <= `WORD_RST;
			loaded_r <= 1'b0;
			enable_r <= `CTRL_RST;
			pend_r <= 1'b0;
			status_r <= `EV_RST;
			mask_r <= `EV_RST;
			reg_rdata_out <= 32'h00000000;
			start_split_out <= 1'b0;
			complete_split_out <= 1'b0;
			buffer_address_out <= 32'h00000000;
			wb_valid_out <= 1'b0;
			wb_word_out <= `WORD_RST;
			irq_out <= 1'b0;
		end
		else
		begin
			desc_r <= desc_nxt;
			loaded_r <= loaded_nxt;
			enable_r <= enable_nxt;
			pend_r <= pend_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			reg_rdata_out <= rdata_nxt;
			start_split_out <= start_nxt;
			complete_split_out <= complete_nxt;
			buffer_address_out <= buf_addr_nxt;
			wb_valid_out <= wb_valid_nxt;
			wb_word_out <= wb_word_nxt;
			irq_out <= irq_nxt;
		end
	end

	property p_start_masked;
		@(posedge clk_in) disable iff (rst_in)
		start_split_out |-> $past(uframe_tick_in && start_hit &&
			phase == PH_START);
	endproperty
	a_start_masked: assert property (p_start_masked)
		else $error("start-split outside start mask");

	property p_complete_masked;
		@(posedge clk_in) disable iff (rst_in)
		complete_split_out |-> $past(uframe_tick_in && comp_hit &&
			phase == PH_COMPLETE);
	endproperty
	a_complete_masked: assert property (p_complete_masked)
		else $error("complete-split outside completion mask");

	property p_phase_advance;
		@(posedge clk_in) disable iff (rst_in)
		(txn_done_in && loaded_r && active && phase == PH_START &&
			!desc_valid_in) |=> desc_r[`W_STATE][`SPLIT_BIT] && wb_valid_out;
	endproperty
	a_phase_advance: assert property (p_phase_advance)
		else $error("split state did not move to complete phase");

	property p_inactive_silent;
		@(posedge clk_in) disable iff (rst_in)
		!active |=> !start_split_out && !complete_split_out;
	endproperty
	a_inactive_silent: assert property (p_inactive_silent)
		else $error("split issued for inactive descriptor");

	property p_done_at_threshold;
		@(posedge clk_in) disable iff (rst_in)
		$rose(status_r[`EV_DONE]) |-> $past(threshold_tick_in && pend_r);
	endproperty
	a_done_at_threshold: assert property (p_done_at_threshold)
		else $error("completion interrupt not at threshold");

	property p_irq_level;
		@(posedge clk_in) disable iff (rst_in)
		irq_out == |(status_r & mask_r);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt output disagrees with status and mask");

	property p_offset_kept;
		@(posedge clk_in) disable iff (rst_in)
		$past(!desc_valid_in) |->
			buffer_address_out == {desc_r[`W_STATE][`PAGE_BIT] ?
			desc_r[`W_PAGE1][31:`PAGE_BASE_LSB] :
			desc_r[`W_PAGE0][31:`PAGE_BASE_LSB],
			desc_r[`W_PAGE0][`OFFSET_MSB:0]};
	endproperty
	a_offset_kept: assert property (p_offset_kept)
		else $error("buffer address offset mismatch");

	property p_wb_state_only;
		@(posedge clk_in) disable iff (rst_in)
		wb_valid_out |-> wb_index_out == `W_STATE &&
			wb_word_out[29:8] == $past(desc_r[`W_STATE][29:8]);
	endproperty
	a_wb_state_only: assert property (p_wb_state_only)
		else $error("write-back altered read-only field");

	property p_one_split;
		@(posedge clk_in) disable iff (rst_in)
		!(start_split_out && complete_split_out);
	endproperty
	a_one_split: assert property (p_one_split)
		else $error("start and complete split together");

endmodule // split_iso_descriptor_decoder

/* testbench/tt_hub_model.sv */
// Behavioural translator hub that answers split tokens after a delay
`timescale 1ns/100ps
module tt_hub_model
(
	input  wire logic       clk_in,
	input  wire logic       ss_in,
	input  wire logic       cs_in,
	input  wire logic [2:0] delay_in,
	input  wire logic       last_in,
	output logic            done_out,
	output logic            last_out
);
	logic [3:0] cnt_r;
	logic       cpl_r;
	initial
	begin
		cnt_r = 4'h0;
		cpl_r = 1'b0;
		done_out = 1'b0;
		last_out = 1'b1;
	end
	always @(posedge clk_in)
	begin
		done_out <= 1'b0;
		// Outside the answer the qualifier toggles so it is never trusted
		last_out <= ~last_out;
		if (ss_in || cs_in)
		begin
			cnt_r <= {1'b0, delay_in} + 4'h1;
			cpl_r <= cs_in;
		end
		else if (cnt_r != 4'h0)
		begin
			cnt_r <= cnt_r - 4'h1;
			if (cnt_r == 4'h1)
			begin
				done_out <= 1'b1;
				last_out <= cpl_r & last_in;
			end
		end
	end
endmodule // tt_hub_model

/* testbench/testbench.sv */
// Self-checking bench of the split isochronous descriptor decoder
`timescale 1ns/100ps
`include "sitd_params.svh"
module testbench;
	import sitd_pkg::*;
	logic        clk_in, rst_in, reg_wr_in, reg_rd_in, desc_valid_in;
	logic        uframe_tick_in, threshold_tick_in, page_advance_in;
	logic        txn_done_in, txn_last_in, start_split_out;
	logic        complete_split_out, dir_in_out, next_link_valid_out;
	logic        back_link_valid_out, wb_valid_out, irq_out, hub_last;
	logic [7:0]  reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, buffer_address_out, q;
	logic [2:0]  desc_index_in, uframe_in, wb_index_out, hub_delay;
	logic [6:0]  translator_port_out, translator_hub_out;
	logic [6:0]  function_address_out;
	logic [3:0]  target_endpoint_out;
	logic [26:0] next_element_link_out, back_link_out;
	logic [1:0]  element_kind_out, transaction_position_out;
	logic [2:0]  transaction_count_out;
	desc_word_t  desc_word_in, wb_word_out;
	desc_word_t  w [7];
	int          n_mismatch, comparisons, cyc, seed;
	logic        es, ec;

	split_iso_descriptor_decoder split_iso_descriptor_decoder_i
	(
		.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .desc_word_in, .desc_index_in,
		.desc_valid_in, .uframe_in, .uframe_tick_in, .threshold_tick_in,
		.txn_done_in, .txn_last_in, .page_advance_in, .start_split_out,
		.complete_split_out, .dir_in_out, .translator_port_out,
		.translator_hub_out, .target_endpoint_out, .function_address_out,
		.buffer_address_out, .next_element_link_out, .element_kind_out,
		.next_link_valid_out, .back_link_out, .back_link_valid_out,
		.transaction_position_out, .transaction_count_out, .wb_valid_out,
		.wb_index_out, .wb_word_out, .irq_out
	);
	tt_hub_model tt_hub_model_i
	(
		.clk_in(clk_in), .ss_in(start_split_out),
		.cs_in(complete_split_out), .delay_in(hub_delay),
		.last_in(hub_last), .done_out(txn_done_in), .last_out(txn_last_in)
	);

	task automatic final_report();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= wr;
		reg_rd_in <= !wr;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		#1;
		q = reg_rdata_out;
	endtask
	// Selector 0 micro-frame tick, 1 threshold tick, 2 page advance
	task automatic pulse(input int sel);
		@(posedge clk_in);
		case (sel)
			0: uframe_tick_in <= 1'b1;
			1: threshold_tick_in <= 1'b1;
			default: page_advance_in <= 1'b1;
		endcase
		@(posedge clk_in);
		{uframe_tick_in, threshold_tick_in, page_advance_in} <= 3'h0;
		#1;
	endtask
	task automatic load();
		for (int i = 0; i < `SITD_WORDS; i++)
		begin
			@(posedge clk_in);
			desc_valid_in <= 1'b1;
			desc_index_in <= i[2:0];
			desc_word_in <= w[i];
		end
		// Index 7 is junk and must leave the store alone
		@(posedge clk_in);
		desc_index_in <= 3'h7;
		desc_word_in <= $random(seed);
		@(posedge clk_in);
		desc_valid_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task automatic chk_dec();
		chk(next_element_link_out, w[0][31:5]);
		chk(element_kind_out, w[0][2:1]);
		chk(next_link_valid_out, !w[0][0]);
		chk({back_link_valid_out, back_link_out}, {!w[6][0], w[6][31:5]});
		chk(dir_in_out, w[1][31]);
		chk(translator_port_out, w[1][30:24]);
		chk({translator_hub_out, target_endpoint_out, function_address_out},
			{w[1][22:16], w[1][11:8], w[1][6:0]});
		chk(buffer_address_out, {w[3][30] ? w[5][31:12] : w[4][31:12],
			w[4][11:0]});
		chk({transaction_position_out, transaction_count_out}, w[5][4:0]);
	endtask
	task automatic wait_wb();
		int n;
		n = 0;
		while (wb_valid_out !== 1'b1 && n < 20)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk({wb_valid_out, wb_index_out}, {1'b1, `W_STATE});
		chk(wb_word_out, w[3]);
	endtask

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	initial
	begin
		seed = 32'h38BF;
		{reg_wr_in, reg_rd_in, desc_valid_in, uframe_tick_in} = 4'h0;
		{threshold_tick_in, page_advance_in, hub_last} = 3'h0;
		{reg_addr_in, reg_wdata_in, desc_word_in} = 72'h0;
		{desc_index_in, uframe_in, hub_delay} = 9'h0;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			foreach (w[i]) w[i] = $random(seed);
			w[0][2:1] = k[1:0];
			load();
			chk_dec();
		end
		foreach (w[i]) w[i] = $random(seed);
		// Link to a frame span node on purpose to raise the bad link event
		w[0][2:0] = {`KIND_FSTN, 1'b0};
		w[1][31] = 1'b0;
		w[2][0] = 1'b1;
		w[2][15] = 1'b1;
		w[3] = 32'h80000080;
		load();
		chk_dec();
		acc(1'b0, `REG_STATE, 32'h0);
		chk(q, 32'h5);
		acc(1'b1, `REG_MASK, 32'h1);
		acc(1'b1, `REG_CTRL, 32'h1);
		for (int uf = 0; uf < 8; uf++)
		begin
			hub_last <= (uf == 7);
			hub_delay <= 3'($random(seed));
			uframe_in <= uf[2:0];
			pulse(0);
			es = w[3][7] & !w[3][1] & w[2][uf];
			ec = w[3][7] & w[3][1] & w[2][8 + uf];
			chk(start_split_out, es);
			chk(complete_split_out, ec);
			if (es)
				w[3][1] = 1'b1;
			if (ec && uf == 7)
				w[3][7:0] = 8'h00;
			if (es || ec)
				wait_wb();
		end
		pulse(0);
		chk({start_split_out, complete_split_out}, 2'h0);
		acc(1'b0, `REG_STATUS, 32'h0);
		chk(q, 32'h6);
		acc(1'b0, `REG_STATE, 32'h0);
		chk(q, 32'h11);
		chk(irq_out, 1'b0);
		pulse(1);
		repeat (2) @(posedge clk_in);
		#1;
		chk(irq_out, 1'b1);
		acc(1'b1, `REG_MASK, 32'h0);
		#20;
		chk(irq_out, 1'b0);
		acc(1'b1, `REG_MASK, 32'h1);
		acc(1'b1, `REG_STATUS, 32'h1);
		#20;
		chk(irq_out, 1'b0);
		acc(1'b0, `REG_STATUS, 32'h0);
		chk(q, 32'h6);
		acc(1'b1, 8'h10, 32'hFFFFFFFF);
		acc(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		acc(1'b0, `REG_CTRL, 32'h0);
		chk(q, 32'h1);
		pulse(2);
		w[3][30] = 1'b1;
		wait_wb();
		repeat (2) @(posedge clk_in);
		#1;
		chk_dec();
		final_report();
	end
endmodule // testbench
